// ===== inc/sac_pkg.sv
// shared constants and types for the serial converter control link
package sac_pkg;
  localparam int RES_W          = 10;    // result width in bits
  localparam int ADDR_W         = 4;     // channel address width
  localparam int XFER_CLKS      = 10;    // transfer clocks per sequence
  localparam int ADDR_CLKS      = 4;     // address clocks, sampling starts after these
  localparam int CONV_CYCLES    = 44;    // conversion clock cycles per conversion
  localparam int SEL_RISE_NEED  = 2;     // conversion clock rises before select falls count
  localparam int CLK_MHZ        = 200;   // core clock rate
  localparam int CONV_MAX_NS    = 21000; // longest conversion from hold instant
  localparam int CONV_MAX_CYC   = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int CCLK_DIV       = 47;    // half period in core cycles; 44 periods fit 21 us
  localparam int XCLK_DIV       = 32;    // core cycles per transfer clock half period
  localparam int FIFO_DEPTH     = 32;    // result buffer depth in words
  localparam logic [3:0] SELF_TEST_CHANNEL = 4'hB;            // internal test voltage
  localparam logic [9:0] SELF_TEST_CODE    = 10'h200;         // mid-scale test result
  localparam logic [9:0] RESULT_RST        = 10'h000;
  typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_CONVERT} sac_conv_e;
endpackage : sac_pkg

// ===== inc/sac_if.sv
// pin-level link between the controller and the converter
`timescale 1ns/1ps
interface sac_if;
  logic sel_n;      // device select, active low
  logic xfer_clk;   // transfer clock
  logic conv_clk;   // conversion clock
  logic addr_in;    // serial address
  logic dout;       // serial result, valid only while dout_oe
  logic dout_oe;    // device drives result pin
  modport dev  (input sel_n, xfer_clk, conv_clk, addr_in, output dout, dout_oe);
  modport host (output sel_n, xfer_clk, conv_clk, addr_in, input dout, dout_oe);
endinterface : sac_if

// ===== rtl/sac_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage has no reset, only pointers and fill count do
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule : sac_fifo

// ===== rtl/sac_dev.sv
// converter end: select filter, serial shifter, sample and conversion sequencer
// Notes on behaviour
// - select high: output floats, inputs ignored
// - select low counts after two rises, one fall
// - msb of old result appears immediately
// - four address bits captured on rising edges
// - first four falls shift bits two to five
// - next five falls shift bits six to ten
// - sampling starts after fourth falling edge
// - tenth fall holds, converts over 44 cycles
// - host then raises select or idles clock
// - select fall resets, aborts conversion
// - new full sequence abandons running conversion
// - select may stay low, ten clocks repeat
// - both clocks independent, no phase relation
// - shared clock: first two clocks skip address
// - shared clock: host raises select at twelfth
// - shared clock: select high converts on it
// - host may strobe hold with tenth fall
// - conversion ends within 21 us of hold
// - address 1011 selects internal test voltage
`timescale 1ns/1ps
module sac_dev (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  sac_if.dev              link,
  input  wire logic [9:0] analog_code_i,  // stand-in for the sampled input level
  output logic      [3:0] channel_o,      // multiplexer address being sampled
  output logic            sampling_o,
  output logic            converting_o,
  output logic            conv_done_o,    // one cycle when a result is latched
  output logic            timeout_o       // conversion ran past its longest time
);
  // three-stage synchronisers for the four pins
  logic [2:0] sel_s_ff, xclk_s_ff, cclk_s_ff, addr_s_ff;
  logic       sel_q_ff, xclk_q_ff, cclk_q_ff;
  logic       sel_n, xclk, cclk, addr;
  logic       xrise, xfall, crise, cfall, sel_fall;

  // pins are asynchronous: second and third stages must agree, except addr which takes the third stage alone
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_s_ff  <= 3'h7;
      xclk_s_ff <= 3'h0;
      cclk_s_ff <= 3'h0;
      addr_s_ff <= 3'h0;
    end else begin
      sel_s_ff  <= {sel_s_ff[1:0], link.sel_n};
      xclk_s_ff <= {xclk_s_ff[1:0], link.xfer_clk};
      cclk_s_ff <= {cclk_s_ff[1:0], link.conv_clk};
      addr_s_ff <= {addr_s_ff[1:0], link.addr_in};
    end
  end

  assign sel_n = (sel_s_ff[2] == sel_s_ff[1]) ? sel_s_ff[2] : sel_q_ff;
  assign xclk  = (xclk_s_ff[2] == xclk_s_ff[1]) ? xclk_s_ff[2] : xclk_q_ff;
  assign cclk  = (cclk_s_ff[2] == cclk_s_ff[1]) ? cclk_s_ff[2] : cclk_q_ff;
  assign addr  = addr_s_ff[2];

  // settled copies for edge detection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_q_ff  <= 1'b1;
      xclk_q_ff <= 1'b0;
      cclk_q_ff <= 1'b0;
    end else begin
      sel_q_ff  <= sel_n;
      xclk_q_ff <= xclk;
      cclk_q_ff <= cclk;
    end
  end

  assign xrise    = xclk && !xclk_q_ff;
  assign xfall    = !xclk && xclk_q_ff;
  assign crise    = cclk && !cclk_q_ff;
  assign cfall    = !cclk && cclk_q_ff;
  assign sel_fall = !sel_n && sel_q_ff;

  // select filter: two conversion clock rises then a fall
  logic [1:0] rise_cnt_ff;
  logic       sel_ok_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rise_cnt_ff <= 2'h0;
      sel_ok_ff   <= 1'b0;
    end else if (sel_n) begin
      rise_cnt_ff <= 2'h0;
      sel_ok_ff   <= 1'b0;
    end else if (!sel_ok_ff) begin
      if (crise && rise_cnt_ff != 2'(sac_pkg::SEL_RISE_NEED))
        rise_cnt_ff <= rise_cnt_ff + 2'h1;
      else if (cfall && rise_cnt_ff == 2'(sac_pkg::SEL_RISE_NEED))
        sel_ok_ff <= 1'b1;
    end
  end

  // a shared clock's first two cycles are eaten by the filter, so edges
  // counted only after acceptance skip the address automatically
  logic       sel_ok_q_ff;
  logic       accept;
  logic [3:0] bit_cnt_ff;
  logic [9:0] shift_ff, hold_ff;
  logic [3:0] addr_sr_ff;
  logic       tenth_fall;
  assign accept     = sel_ok_ff && !sel_ok_q_ff;
  assign tenth_fall = sel_ok_ff && xfall && bit_cnt_ff == 4'(sac_pkg::XFER_CLKS - 1);

  // transfer shifter; counter wraps so ten clocks repeat while select low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_ok_q_ff <= 1'b0;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= sac_pkg::RESULT_RST;
      addr_sr_ff  <= 4'h0;
    end else begin
      sel_ok_q_ff <= sel_ok_ff;
      if (accept) begin
        bit_cnt_ff <= 4'h0;
        shift_ff   <= hold_ff;
      end else if (sel_ok_ff) begin
        if (xrise && bit_cnt_ff < 4'(sac_pkg::ADDR_CLKS))
          addr_sr_ff <= {addr_sr_ff[2:0], addr};
        if (xfall) begin
          if (tenth_fall) begin
            bit_cnt_ff <= 4'h0;
            shift_ff   <= hold_ff;
          end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            shift_ff   <= {shift_ff[8:0], 1'b0};
          end
        end
      end
    end
  end

  // conversion sequencer on conversion clock enables
  sac_pkg::sac_conv_e st_ff;
  logic [5:0]  ccnt_ff;
  logic [12:0] tcnt_ff;
  logic [3:0]  chan_ff;
  logic [9:0]  samp_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff   <= sac_pkg::SAC_IDLE;
      ccnt_ff <= 6'h0;
      chan_ff <= 4'h0;
      samp_ff <= sac_pkg::RESULT_RST;
      hold_ff <= sac_pkg::RESULT_RST;
    end else if (sel_fall) begin
      st_ff <= sac_pkg::SAC_IDLE;
    end else begin
      case (st_ff)
        sac_pkg::SAC_IDLE: begin
          if (sel_ok_ff && xfall && bit_cnt_ff == 4'(sac_pkg::ADDR_CLKS - 1)) begin
            st_ff   <= sac_pkg::SAC_SAMPLE;
            chan_ff <= addr_sr_ff;
          end
        end
        sac_pkg::SAC_SAMPLE: begin
          if (tenth_fall) begin
            st_ff   <= sac_pkg::SAC_CONVERT;
            ccnt_ff <= 6'h0;
            samp_ff <= (chan_ff == sac_pkg::SELF_TEST_CHANNEL) ?
                       sac_pkg::SELF_TEST_CODE : analog_code_i;
          end
        end
        sac_pkg::SAC_CONVERT: begin
          // a new address phase abandons this conversion; hold keeps old result
          if (sel_ok_ff && xfall && bit_cnt_ff == 4'(sac_pkg::ADDR_CLKS - 1)) begin
            st_ff   <= sac_pkg::SAC_SAMPLE;
            chan_ff <= addr_sr_ff;
          end else if (crise) begin
            if (ccnt_ff == 6'(sac_pkg::CONV_CYCLES - 1)) begin
              st_ff   <= sac_pkg::SAC_IDLE;
              hold_ff <= samp_ff;
            end else begin
              ccnt_ff <= ccnt_ff + 6'h1;
            end
          end
        end
        default: st_ff <= sac_pkg::SAC_IDLE;
      endcase
    end
  end

  // watchdog on the longest conversion time
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tcnt_ff   <= 13'h0;
      timeout_o <= 1'b0;
    end else if (st_ff != sac_pkg::SAC_CONVERT) begin
      tcnt_ff <= 13'h0;
    end else begin
      tcnt_ff <= tcnt_ff + 13'h1;
      if (tcnt_ff == 13'(sac_pkg::CONV_MAX_CYC)) timeout_o <= 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.dout    <= 1'b0;
      link.dout_oe <= 1'b0;
      channel_o    <= 4'h0;
      sampling_o   <= 1'b0;
      converting_o <= 1'b0;
      conv_done_o  <= 1'b0;
    end else begin
      link.dout    <= accept ? hold_ff[9] : shift_ff[9];
      link.dout_oe <= sel_ok_ff && !sel_n;
      channel_o    <= chan_ff;
      sampling_o   <= st_ff == sac_pkg::SAC_SAMPLE;
      converting_o <= st_ff == sac_pkg::SAC_CONVERT;
      conv_done_o  <= st_ff == sac_pkg::SAC_CONVERT && crise && !sel_fall &&
                      ccnt_ff == 6'(sac_pkg::CONV_CYCLES - 1) &&
                      !(sel_ok_ff && xfall && bit_cnt_ff == 4'(sac_pkg::ADDR_CLKS - 1));
    end
  end
endmodule : sac_dev

// ===== rtl/sac_host.sv
// controller end: makes both clocks, runs ten-clock sequences, buffers results
`timescale 1ns/1ps
module sac_host (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  sac_if.host             link,
  input  wire logic       start_i,      // request one sequence
  input  wire logic [3:0] channel_i,    // address for that sequence
  output logic            busy_o,
  output logic            res_valid_o,
  input  wire logic       res_ready_i,
  output logic      [9:0] res_data_o
);
  typedef enum logic [2:0] {SH_IDLE, SH_WAIT, SH_XFER, SH_CONV} sh_state_e;
  sh_state_e  st_ff;
  logic [5:0] cdiv_ff, xdiv_ff;
  logic [3:0] edge_cnt_ff;
  logic [5:0] cc_cnt_ff;
  logic [3:0] addr_ff;
  logic [9:0] rx_ff;
  logic [2:0] din_s_ff;
  logic       push_ff;
  logic       fifo_ready, fifo_valid;
  logic [9:0] fifo_data;

  // conversion clock runs free from a divider
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cdiv_ff       <= 6'h0;
      link.conv_clk <= 1'b0;
    end else if (cdiv_ff == 6'(sac_pkg::CCLK_DIV - 1)) begin
      cdiv_ff       <= 6'h0;
      link.conv_clk <= !link.conv_clk;
    end else begin
      cdiv_ff <= cdiv_ff + 6'h1;
    end
  end

  // result pin passes three stages
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) din_s_ff <= 3'h0;
    else din_s_ff <= {din_s_ff[1:0], link.dout};
  end

  // sequence: select low, wait filter, ten clocks, idle through conversion;
  // a new start is refused while the fifo is full
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff         <= SH_IDLE;
      link.sel_n    <= 1'b1;
      link.xfer_clk <= 1'b0;
      link.addr_in  <= 1'b0;
      xdiv_ff       <= 6'h0;
      edge_cnt_ff   <= 4'h0;
      cc_cnt_ff     <= 6'h0;
      addr_ff       <= 4'h0;
      rx_ff         <= 10'h000;
      push_ff       <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      push_ff <= 1'b0;
      xdiv_ff <= (xdiv_ff == 6'(sac_pkg::XCLK_DIV - 1)) ? 6'h0 : xdiv_ff + 6'h1;
      case (st_ff)
        SH_IDLE: begin
          if (start_i && fifo_ready) begin
            st_ff      <= SH_WAIT;
            link.sel_n <= 1'b0;
            addr_ff    <= channel_i;
            busy_o     <= 1'b1;
            xdiv_ff    <= 6'h0;
            edge_cnt_ff <= 4'h0;
          end
        end
        SH_WAIT: begin
          // wait well past the select filter (several conversion clocks)
          if (xdiv_ff == 6'(sac_pkg::XCLK_DIV - 1)) begin
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
            if (edge_cnt_ff == 4'hF) begin
              st_ff        <= SH_XFER;
              link.addr_in <= addr_ff[3];
              rx_ff        <= {9'h000, din_s_ff[2]};
              edge_cnt_ff  <= 4'h0;
            end
          end
        end
        SH_XFER: begin
          if (xdiv_ff == 6'(sac_pkg::XCLK_DIV - 1)) begin
            link.xfer_clk <= !link.xfer_clk;
            if (link.xfer_clk) begin
              // falling edge: next address bit; sample result bit late in low half
              addr_ff      <= {addr_ff[2:0], 1'b0};
              link.addr_in <= addr_ff[2];
              edge_cnt_ff  <= edge_cnt_ff + 4'h1;
              if (edge_cnt_ff == 4'(sac_pkg::XFER_CLKS - 1)) begin
                st_ff     <= SH_CONV;
                cc_cnt_ff <= 6'h0;
              end
            end else if (edge_cnt_ff != 4'h0) begin
              rx_ff <= {rx_ff[8:0], din_s_ff[2]};
            end
          end
        end
        SH_CONV: begin
          // deselect once the conversion is surely over, then stay high a full
          // conversion clock so the converter's filter really sees the high level
          if (cdiv_ff == 6'h0 && !link.conv_clk) begin
            cc_cnt_ff <= cc_cnt_ff + 6'h1;
            if (cc_cnt_ff == 6'(sac_pkg::CONV_CYCLES + 1)) begin
              link.sel_n <= 1'b1;
              push_ff    <= 1'b1;
            end else if (cc_cnt_ff == 6'(sac_pkg::CONV_CYCLES + 2)) begin
              st_ff  <= SH_IDLE;
              busy_o <= 1'b0;
            end
          end
        end
        default: st_ff <= SH_IDLE;
      endcase
    end
  end

  sac_fifo #(.WIDTH(sac_pkg::RES_W), .DEPTH(sac_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_ff),
    .in_ready_o  (fifo_ready),
    .in_data_i   (rx_ff),
    .out_valid_o (fifo_valid),
    .out_ready_i (res_ready_i && !res_valid_o),
    .out_data_o  (fifo_data)
  );

  // registered output stage over the fifo
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_valid_o <= 1'b0;
      res_data_o  <= 10'h000;
    end else if (res_valid_o) begin
      if (res_ready_i) res_valid_o <= 1'b0;
    end else if (fifo_valid && res_ready_i) begin
      res_valid_o <= 1'b1;
      res_data_o  <= fifo_data;
    end
  end
endmodule : sac_host

// ===== verif/sac_assertions.sv
// pin-level checks on the link between controller and converter
`timescale 1ns/1ps
module sac_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sel_n,
  input wire logic xfer_clk,
  input wire logic conv_clk,
  input wire logic addr_in,
  input wire logic dout,
  input wire logic dout_oe
);
  logic       xfer_q_ff;
  logic       conv_q_ff;
  logic [3:0] fall_cnt_ff;   // transfer falls in this frame
  logic [1:0] stage_ff;      // filter stage since select fell: two conversion rises, then a fall
  logic [5:0] conv_cnt_ff;   // conversion rises since the tenth fall
  logic [3:0] since_ff;      // core cycles since last transfer fall
  logic       xfer_fall;
  logic       conv_rise;
  logic       conv_fall;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // edge finders on the sampled link clocks
  assign xfer_fall = xfer_q_ff & ~xfer_clk;
  assign conv_rise = ~conv_q_ff & conv_clk;
  assign conv_fall = conv_q_ff & ~conv_clk;

  // delayed copies of both clocks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_q_ff <= 1'b0;
      conv_q_ff <= 1'b0;
    end else begin
      xfer_q_ff <= xfer_clk;
      conv_q_ff <= conv_clk;
    end
  end

  // frame position, cleared while select is high
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fall_cnt_ff <= 4'h0;
      stage_ff    <= 2'h0;
    end else if (sel_n) begin
      fall_cnt_ff <= 4'h0;
      stage_ff    <= 2'h0;
    end else begin
      if (xfer_fall && fall_cnt_ff != 4'hF) fall_cnt_ff <= fall_cnt_ff + 4'h1;
      if (stage_ff < 2'h2 && conv_rise) stage_ff <= stage_ff + 2'h1;
      else if (stage_ff == 2'h2 && conv_fall) stage_ff <= 2'h3;
    end
  end

  // saturating timers so long idle stretches never wrap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_cnt_ff <= 6'h3F;
      since_ff    <= 4'hF;
    end else begin
      if (xfer_fall && fall_cnt_ff == 4'h9) conv_cnt_ff <= 6'h00;
      else if (conv_rise && conv_cnt_ff != 6'h3F) conv_cnt_ff <= conv_cnt_ff + 6'h01;
      if (xfer_fall) since_ff <= 4'h0;
      else if (since_ff != 4'hF) since_ff <= since_ff + 4'h1;
    end
  end

  sequence s_frame_end;
    !sel_n ##1 sel_n;
  endsequence

  sequence s_accept;
    $rose(stage_ff == 2'h3);
  endsequence

  chk_oe_off_idle: assert property (sel_n [*8] |-> !dout_oe)
    else $error("result pin driven while deselected");
  chk_clk_in_frame: assert property ($changed(xfer_clk) |-> !sel_n)
    else $error("transfer clock moved outside a frame");
  chk_sel_filter: assert property ($rose(dout_oe) |-> stage_ff == 2'h3)
    else $error("select accepted before two rises and a fall");
  chk_oe_prompt: assert property (s_accept |-> ##[0:8] (dout_oe || sel_n))
    else $error("result pin not driven after select accepted");
  chk_shift_on_fall: assert property (
    (dout_oe && $past(dout_oe) && $changed(dout) && fall_cnt_ff < 4'hA) |-> since_ff <= 4'hA)
    else $error("result bit changed away from a transfer fall");
  chk_ten_per_frame: assert property (s_frame_end |-> fall_cnt_ff == 4'hA)
    else $error("frame did not hold ten transfer clocks");
  chk_hold_clk_low: assert property ((fall_cnt_ff == 4'hA && !sel_n) |-> !xfer_clk)
    else $error("transfer clock rose during conversion");
  chk_conv_window: assert property (s_frame_end |-> conv_cnt_ff >= 6'h2C)
    else $error("select raised before conversion finished");
  cov_addr_one: cover property (fall_cnt_ff == 4'h3 && addr_in);
endmodule : sac_assertions

// ===== verif/tb_top.sv
// self-checking bench: controller and converter joined by the link
`timescale 1ns/1ps
module tb_top;
  logic       clk_i;
  logic       rst_i;
  logic       start_i;
  logic [3:0] channel_i;
  logic       busy_o;
  logic       res_valid_o;
  logic       res_ready_i;
  logic [9:0] res_data_o;
  logic [9:0] analog_code_i;
  logic [3:0] channel_o;
  logic       sampling_o;
  logic       converting_o;
  logic       conv_done_o;
  logic       timeout_o;
  logic [7:0] lfsr_ff;
  logic [9:0] prev_res;
  logic [9:0] exp_q[$];
  logic       saw_sample;
  logic       saw_conv;
  int         err_total;
  int         num_checks;
  int         cyc;
  int         got_cnt;
  int         done_cnt;

  sac_if link();
  sac_host i_sac_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .start_i(start_i),
    .channel_i(channel_i), .busy_o(busy_o), .res_valid_o(res_valid_o),
    .res_ready_i(res_ready_i), .res_data_o(res_data_o));
  sac_dev i_sac_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link), .analog_code_i(analog_code_i),
    .channel_o(channel_o), .sampling_o(sampling_o), .converting_o(converting_o),
    .conv_done_o(conv_done_o), .timeout_o(timeout_o));
  sac_assertions i_sac_assertions (.clk_i(clk_i), .rst_i(rst_i), .sel_n(link.sel_n),
    .xfer_clk(link.xfer_clk), .conv_clk(link.conv_clk), .addr_in(link.addr_in),
    .dout(link.dout), .dout_oe(link.dout_oe));

  // core clock, 5 ns period
  initial clk_i = 1'b0;
  always #2.5 clk_i = ~clk_i;

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp10

  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
    cmp10({6'h00, got}, {6'h00, exp});
  endtask : cmp4

  task automatic cmp1(input logic got, input logic exp);
    cmp10({9'h000, got}, {9'h000, exp});
  endtask : cmp1

  // bounded wait, then the level itself is a result
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_o !== lvl && n < 20000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp1(busy_o, lvl);
  endtask : wait_busy

  // one sequence; the reply carries the previous conversion
  task automatic run_seq(input logic [3:0] ch, input logic [9:0] code);
    wait_busy(1'b0);
    exp_q.push_back(prev_res);
    prev_res = (ch == sac_pkg::SELF_TEST_CHANNEL) ? sac_pkg::SELF_TEST_CODE : code;
    saw_sample = 1'b0;
    saw_conv = 1'b0;
    start_i = 1'b1;
    channel_i = ch;
    analog_code_i = code;
    wait_busy(1'b1);
    start_i = 1'b0;
    // a start while busy must be dropped, not queued
    repeat (20) @(posedge clk_i);
    #1 start_i = 1'b1;
    channel_i = ~ch;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    channel_i = ch;
    wait_busy(1'b0);
    cmp4(channel_o, ch);
    cmp1(saw_sample, 1'b1);
    cmp1(saw_conv, 1'b1);
    cmp1(timeout_o, 1'b0);
  endtask : run_seq

  // idle state straight after reset: link parked, nothing offered
  task automatic reset_check();
    @(posedge clk_i);
    #1;
    cmp1(link.sel_n, 1'b1);
    cmp1(link.dout_oe, 1'b0);
    cmp1(busy_o, 1'b0);
    cmp1(res_valid_o, 1'b0);
  endtask : reset_check

  // result monitor, flags and hang guard; looks mid-cycle so outputs have settled
  always @(negedge clk_i) begin
    cyc++;
    if (sampling_o === 1'b1) saw_sample = 1'b1;
    if (converting_o === 1'b1) saw_conv = 1'b1;
    if (conv_done_o === 1'b1) done_cnt++;
    if (res_valid_o === 1'b1 && res_ready_i === 1'b1) begin
      got_cnt++;
      cmp10(res_data_o, (exp_q.size() > 0) ? exp_q.pop_front() : ~res_data_o);
    end
    if (cyc == 60000) begin  // seven frames need about 40k cycles
      err_total++;
      $display("unexpected timeout at %0t", $time);
      test_done();
    end
  end

  initial begin
    logic [3:0] ch;
    logic [9:0] code;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    got_cnt = 0;
    done_cnt = 0;
    start_i = 1'b0;
    channel_i = 4'h0;
    analog_code_i = 10'h000;
    res_ready_i = 1'b1;
    lfsr_ff = 8'h53;
    prev_res = sac_pkg::RESULT_RST;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    reset_check();
    for (int k = 0; k < 7; k++) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      ch = (k == 2) ? sac_pkg::SELF_TEST_CHANNEL : 4'(lfsr_ff % 8'h0B);
      lfsr_ff = lfsr_next(lfsr_ff);
      code = (k == 5) ? 10'h3FF : (k == 6) ? 10'h000 : {lfsr_ff, lfsr_ff[7:6]};
      res_ready_i = (k == 3 || k == 4) ? 1'b0 : 1'b1; // reader stalls over two frames
      run_seq(ch, code);
    end
    res_ready_i = 1'b1;
    for (int n = 0; n < 2000 && exp_q.size() > 0; n++) begin
      @(posedge clk_i);
      #1;
    end
    cmp10(10'(got_cnt), 10'h007);
    cmp10(10'(done_cnt), 10'h007);
    test_done();
  end
endmodule : tb_top
